//--- pkg/mocfg_pkg.sv
package mocfg_pkg;
   // ************************************************************
   // register map and field layout
   // ************************************************************
   localparam int unsigned MOCFG_ADDR_W = 10;                    // register address width
   localparam logic [9:0] MOCFG_OPMODE_ONE_OFFSET = 10'h002;    // operating_mode_one
   localparam logic [7:0] MOCFG_OPMODE_ONE_RESET = 8'h00;       // value after reset
   localparam logic [7:0] MOCFG_OPMODE_ONE_WMASK = 8'h0f;       // bits 7:4 reserved
   localparam logic [7:0] MOCFG_UNMAPPED_DATA = 8'h00;          // read of other offsets
   localparam int unsigned MOCFG_CHECK_BIT = 3;                  // spi_check_byte_enable
   localparam int unsigned MOCFG_POLARITY_BIT = 2;               // pulse_output_polarity
   localparam int unsigned MOCFG_CONN_LSB = 0;                   // phase_connection_select

   // ************************************************************
   // connection encodings
   // ************************************************************
   localparam logic [1:0] MOCFG_CONN_OWN = 2'h0;        // each phase own voltage
   localparam logic [1:0] MOCFG_CONN_NEG_C = 2'h1;      // b uses -vc
   localparam logic [1:0] MOCFG_CONN_NEG_AC = 2'h2;     // b uses -va-vc
   localparam logic [1:0] MOCFG_CONN_A_MINUS_C = 2'h3;  // b uses va-vc

   // ************************************************************
   // datapath widths and pulse generator
   // ************************************************************
   localparam int unsigned MOCFG_SAMPLE_W = 16;  // current and voltage samples
   localparam int unsigned MOCFG_VOLT_W = 17;    // phase b voltage after sum
   localparam int unsigned MOCFG_POWER_W = 33;   // signed product width
   localparam int unsigned MOCFG_PULSE_N = 2;    // number of pulse outputs
   localparam int unsigned MOCFG_WIDTH_W = 16;   // pulse width in clock cycles
   localparam logic [15:0] MOCFG_WIDTH_ZERO = 16'h0000;  // idle count

   // one set of phase samples
   typedef struct packed {
      logic signed [15:0] ia;
      logic signed [15:0] ib;
      logic signed [15:0] ic;
      logic signed [15:0] va;
      logic signed [15:0] vb;
      logic signed [15:0] vc;
   } mocfg_sample_type;

   // per-phase power results
   typedef struct packed {
      logic signed [32:0] pa;
      logic signed [32:0] pb;
      logic signed [32:0] pc;
   } mocfg_power_type;
endpackage : mocfg_pkg

//--- verilog/mocfg_opmode_one.sv
`timescale 1ns/10ps
module mocfg_opmode_one import mocfg_pkg::*; (
   // clock, reset, enable
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   // register access from spi command decoder
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // spi framing control
   output logic spi_check_byte_enable,
   // pulse generators
   input wire logic [1:0] pulse_event,
   input wire logic [15:0] pulse_width,
   output logic [1:0] pulse_out,
   // measurement datapath
   input wire logic sample_valid,
   input wire mocfg_sample_type sample,
   output mocfg_power_type power,
   output logic power_valid
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic [7:0] operating_mode_one;                 // the register
   logic pulse_output_polarity;                    // field view
   logic [1:0] phase_connection_select;            // field view
   logic [15:0] pulse_count [MOCFG_PULSE_N];       // remaining active cycles
   logic [15:0] next_pulse_count [MOCFG_PULSE_N];  // count after this edge
   logic signed [16:0] next_vb;                    // phase b voltage chosen

   assign pulse_output_polarity = operating_mode_one[MOCFG_POLARITY_BIT];
   assign phase_connection_select = operating_mode_one[MOCFG_CONN_LSB +: 2];

   // signed current times voltage
   function automatic logic signed [32:0] phase_product(
      input logic signed [15:0] cur,
      input logic signed [16:0] volt
   );
      phase_product = cur * volt;
   endfunction : phase_product

   // ************************************************************
   // register write
   // ************************************************************
   // reserved bits masked on write, reset clears all
   always_ff @(posedge clock) begin
      if (srst) begin
         operating_mode_one <= MOCFG_OPMODE_ONE_RESET;
      end else if (ce) begin
         if (reg_wr && reg_addr == MOCFG_OPMODE_ONE_OFFSET) begin
            operating_mode_one <= reg_wdata & MOCFG_OPMODE_ONE_WMASK;
         end
      end
   end

   // ************************************************************
   // register read
   // ************************************************************
   // read data registered one cycle after the strobe
   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rdata <= MOCFG_OPMODE_ONE_RESET;
      end else if (ce && reg_rd) begin
         if (reg_addr == MOCFG_OPMODE_ONE_OFFSET) begin
            reg_rdata <= operating_mode_one;
         end else begin
            reg_rdata <= MOCFG_UNMAPPED_DATA;  // unmapped offset
         end
      end
   end

   // ************************************************************
   // spi check byte control
   // ************************************************************
   // framer appends crc to reads and expects one after writes
   always_ff @(posedge clock) begin
      if (srst) begin
         spi_check_byte_enable <= 1'b0;
      end else if (ce) begin
         spi_check_byte_enable <= operating_mode_one[MOCFG_CHECK_BIT];
      end
   end

   // ************************************************************
   // pulse generators
   // ************************************************************
   // event while idle loads width; events during a pulse are dropped
   always_comb begin
      for (int i = 0; i < MOCFG_PULSE_N; i++) begin
         if (pulse_count[i] != MOCFG_WIDTH_ZERO) begin
            next_pulse_count[i] = pulse_count[i] - 16'h0001;
         end else if (pulse_event[i]) begin
            next_pulse_count[i] = pulse_width;
         end else begin
            next_pulse_count[i] = MOCFG_WIDTH_ZERO;
         end
      end
   end

   // counters and pin levels; active level follows polarity
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < MOCFG_PULSE_N; i++) begin
            pulse_count[i] <= MOCFG_WIDTH_ZERO;
         end
         pulse_out <= 2'h3;  // reset polarity is active low
      end else if (ce) begin
         for (int i = 0; i < MOCFG_PULSE_N; i++) begin
            pulse_count[i] <= next_pulse_count[i];
            // active is low when clear, high when set
            pulse_out[i] <= ~((next_pulse_count[i] != MOCFG_WIDTH_ZERO)
                              ^ pulse_output_polarity);
         end
      end
   end

   // ************************************************************
   // per-phase power
   // ************************************************************
   // phase b voltage per connection select
   always_comb begin
      case (phase_connection_select)
         MOCFG_CONN_NEG_C: begin
            next_vb = -17'(sample.vc);
         end
         MOCFG_CONN_NEG_AC: begin
            next_vb = -17'(sample.va) - 17'(sample.vc);
         end
         MOCFG_CONN_A_MINUS_C: begin
            next_vb = 17'(sample.va) - 17'(sample.vc);
         end
         default: begin
            next_vb = 17'(sample.vb);
         end
      endcase
   end

   // products registered on each valid sample
   always_ff @(posedge clock) begin
      if (srst) begin
         power <= '0;
         power_valid <= 1'b0;
      end else if (ce) begin
         power_valid <= sample_valid;
         if (sample_valid) begin
            power.pa <= phase_product(sample.ia, 17'(sample.va));
            power.pb <= phase_product(sample.ib, next_vb);
            power.pc <= phase_product(sample.ic, 17'(sample.vc));
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_reserved_read_zero: assert property (
      reg_rdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");

   a_reset_clears_reg: assert property (
      $past(srst) |-> operating_mode_one == 8'h00)
      else $error("register not zero after reset");

   a_write_then_read: assert property (
      ce && reg_wr && !reg_rd && reg_addr == 10'h002 ##1 ce && reg_rd && !reg_wr
      && reg_addr == 10'h002 |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0f))
      else $error("read back differs from masked write");

   a_check_byte_follow: assert property (
      ce && reg_wr && reg_addr == 10'h002 ##1 ce
      |=> spi_check_byte_enable == $past(reg_wdata[3], 2))
      else $error("check byte enable not following register");

   a_idle_high_clear: assert property (
      ce && !pulse_output_polarity && pulse_count[0] == 16'h0000 && !pulse_event[0]
      |=> pulse_out[0] == 1'b1)
      else $error("pulse output not idle high");

   a_idle_low_set: assert property (
      ce && pulse_output_polarity && pulse_count[1] == 16'h0000 && !pulse_event[1]
      |=> pulse_out[1] == 1'b0)
      else $error("pulse output not idle low");

   // polarity held still by barring writes over the three taking edges
   a_pulse_two_wide: assert property (
      ce && !reg_wr && pulse_count[0] == MOCFG_WIDTH_ZERO && pulse_event[0]
      && pulse_width == 16'h0002 ##1 ce && !reg_wr ##1 ce && !reg_wr
      |-> $past(pulse_out[0]) == pulse_output_polarity
      && pulse_out[0] == pulse_output_polarity
      ##1 pulse_out[0] != pulse_output_polarity)
      else $error("pulse not exactly two cycles");

   a_power_own: assert property (
      ce && sample_valid && phase_connection_select == 2'h0
      |=> power.pb == $past(sample.ib) * $past(sample.vb))
      else $error("phase b power wrong in own mode");

   a_power_neg_c: assert property (
      ce && sample_valid && phase_connection_select == 2'h1
      |=> power.pb == 33'($past(sample.ib) * -17'($past(sample.vc))))
      else $error("phase b power wrong in neg c mode");

   a_power_neg_ac: assert property (
      ce && sample_valid && phase_connection_select == 2'h2
      |=> power.pb == 33'($past(sample.ib)
      * (-17'($past(sample.va)) - 17'($past(sample.vc)))))
      else $error("phase b power wrong in neg sum mode");

   a_power_a_minus_c: assert property (
      ce && sample_valid && phase_connection_select == 2'h3
      |=> power.pb == 33'($past(sample.ib)
      * (17'($past(sample.va)) - 17'($past(sample.vc)))) && power.pa ==
      33'($past(sample.ia) * $past(sample.va)))
      else $error("power wrong in a minus c mode");

   c_check_enabled: cover property (spi_check_byte_enable);
   c_pulse_active_high: cover property (pulse_output_polarity && pulse_out[0]);
   c_mode_neg_ac: cover property (power_valid && phase_connection_select == 2'h2);
   c_unmapped_read: cover property (ce && reg_rd && reg_addr != 10'h002);
endmodule : mocfg_opmode_one

//--- dv/mocfg_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// host side of the register port
// ************************************************************
module mocfg_host_model import mocfg_pkg::*; (
   // clock and framing state
   input wire logic clock,
   input wire logic spi_check_byte_enable,
   // register strobes toward the device
   output logic reg_wr,
   output logic reg_rd,
   output logic [9:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   logic crc_due; // host owes a check byte after each write
   assign crc_due = spi_check_byte_enable;
   int crc_bytes_sent = 0; // check bytes appended after writes
   // idle lines at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 10'h3fd;
      reg_wdata = 8'h00;
   end
   // one write, strobe held across one rising edge
   task automatic write_reg(input logic [9:0] addr, input logic [7:0] data);
      @(negedge clock);
      if (crc_due) begin
         crc_bytes_sent++;
      end
      reg_wr = 1'b1;
      reg_addr = addr;
      reg_wdata = data;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_addr = ~addr; // released lines show the inverse
      reg_wdata = ~data;
   endtask : write_reg
   // one read, data taken at the falling edge half a cycle after the taking edge
   task automatic read_reg(input logic [9:0] addr, output logic [7:0] data);
      @(negedge clock);
      reg_rd = 1'b1;
      reg_addr = addr;
      @(negedge clock);
      reg_rd = 1'b0;
      reg_addr = ~addr;
      data = reg_rdata;
   endtask : read_reg
   // write, then read in the very next cycle, data taken one cycle later
   task automatic write_read_reg(input logic [9:0] addr, input logic [7:0] wdata,
                                 output logic [7:0] rdata);
      @(negedge clock);
      if (crc_due) begin
         crc_bytes_sent++;
      end
      reg_wr = 1'b1;
      reg_addr = addr;
      reg_wdata = wdata;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      reg_addr = ~addr;
      reg_wdata = ~wdata;
      rdata = reg_rdata;
   endtask : write_read_reg
endmodule : mocfg_host_model

//--- dv/mocfg_opmode_one_tb_top.sv
`timescale 1ns/10ps
// ************************************************************
// bench top
// ************************************************************
module mocfg_opmode_one_tb_top import mocfg_pkg::*; ;
   logic clock, srst, ce, reg_wr, reg_rd, spi_check_byte_enable, sample_valid, power_valid;
   logic [9:0] reg_addr; // register offset
   logic [7:0] reg_wdata, reg_rdata, rd; // bus data
   logic [1:0] pulse_event, pulse_out; // pulse channels
   logic [15:0] pulse_width; // active length
   logic [2:0] c; // connection loop index
   mocfg_sample_type sample; // phase samples
   mocfg_power_type power; // phase powers
   int mismatches = 0, check_count = 0, cycles = 0;
   mocfg_opmode_one dut_u (.clock(clock), .srst(srst), .ce(ce), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .spi_check_byte_enable(spi_check_byte_enable), .pulse_event(pulse_event),
      .pulse_width(pulse_width), .pulse_out(pulse_out), .sample_valid(sample_valid),
      .sample(sample), .power(power), .power_valid(power_valid));
   mocfg_host_model host_u (.clock(clock), .spi_check_byte_enable(spi_check_byte_enable),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         complete_run();
      end
   end
   // compare and count
   task automatic check(input string name, input logic [98:0] exp, input logic [98:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // verdict and stop
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   // one pulse of a given width on channel 0 at a given polarity
   task automatic pulse_test(input logic pol, input logic [15:0] w);
      int i;
      logic [1:0] idle;
      idle = pol ? 2'h0 : 2'h3;
      host_u.write_reg(MOCFG_OPMODE_ONE_OFFSET, {5'h00, pol, 2'h0});
      @(negedge clock);
      check("pulse idle", idle, pulse_out);
      pulse_width = w;
      pulse_event = 2'h1;
      @(negedge clock);
      pulse_event = 2'h0;
      for (i = 0; i < w; i++) begin
         check("pulse active", {idle[1], ~idle[0]}, pulse_out);
         @(negedge clock);
      end
      check("pulse end", idle, pulse_out);
   endtask : pulse_test
   // sample taken right after the connection write
   task automatic power_test(input logic [1:0] conn);
      logic signed [16:0] v;
      logic signed [32:0] ea, eb, ec;
      host_u.write_reg(MOCFG_OPMODE_ONE_OFFSET, {6'h00, conn});
      case (conn)
         MOCFG_CONN_OWN: v = sample.vb;
         MOCFG_CONN_NEG_C: v = -sample.vc;
         MOCFG_CONN_NEG_AC: v = -sample.va - sample.vc;
         default: v = sample.va - sample.vc;
      endcase
      ea = sample.ia * sample.va;
      eb = sample.ib * v;
      ec = sample.ic * sample.vc;
      sample_valid = 1'b1;
      @(negedge clock);
      sample_valid = 1'b0;
      check("power valid", 1'b1, power_valid);
      check("power", {ea, eb, ec}, power);
      @(negedge clock);
      check("power valid end", 1'b0, power_valid);
   endtask : power_test
   // main sequence
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      pulse_event = 2'b00;
      pulse_width = 16'h0000;
      sample_valid = 1'b0;
      sample = {16'h1234, 16'h7fff, 16'hc001, 16'h8001, 16'h2345, 16'h9000};
      repeat (10) @(negedge clock);
      srst = 1'b0;
      check("check enable", 1'b0, spi_check_byte_enable);
      check("idle pins", 2'b11, pulse_out);
      host_u.read_reg(MOCFG_OPMODE_ONE_OFFSET, rd);
      check("reset value", MOCFG_OPMODE_ONE_RESET, rd);
      host_u.write_reg(MOCFG_OPMODE_ONE_OFFSET, 8'hff);
      host_u.read_reg(MOCFG_OPMODE_ONE_OFFSET, rd);
      check("reserved bits", 8'h0f, rd);
      check("check enable", 1'b1, spi_check_byte_enable);
      host_u.write_reg(10'h003, 8'h00);
      host_u.read_reg(MOCFG_OPMODE_ONE_OFFSET, rd);
      check("unmapped write", 8'h0f, rd);
      host_u.read_reg(10'h003, rd);
      check("unmapped read", 8'h00, rd);
      host_u.write_read_reg(MOCFG_OPMODE_ONE_OFFSET, 8'hfd, rd);
      check("write read back", 8'h0d, rd);
      ce = 1'b0;
      host_u.write_reg(MOCFG_OPMODE_ONE_OFFSET, 8'h00);
      ce = 1'b1;
      host_u.read_reg(MOCFG_OPMODE_ONE_OFFSET, rd);
      check("frozen write", 8'h0d, rd);
      check("frozen check enable", 1'b1, spi_check_byte_enable);
      host_u.write_reg(MOCFG_OPMODE_ONE_OFFSET, 8'h00);
      @(negedge clock);
      check("check enable", 1'b0, spi_check_byte_enable);
      pulse_test(1'b0, 16'h0003);
      pulse_test(1'b1, 16'h0002);
      for (c = 3'h0; c < 3'h4; c++) begin
         power_test(c[1:0]);
      end
      check("check bytes", 4, host_u.crc_bytes_sent);
      // second reset in mid-run with nonzero register and power
      srst = 1'b1;
      repeat (2) @(negedge clock);
      srst = 1'b0;
      check("reset power", 99'h0, power);
      check("reset valid", 1'b0, power_valid);
      check("reset check enable", 1'b0, spi_check_byte_enable);
      check("reset pins", 2'h3, pulse_out);
      host_u.read_reg(MOCFG_OPMODE_ONE_OFFSET, rd);
      check("reset again", MOCFG_OPMODE_ONE_RESET, rd);
      complete_run();
   end
endmodule : mocfg_opmode_one_tb_top
